// File: inc/cpaa_defines.svh
// Constants for the port access arbiter: register selects, fields, opcodes
// Assumes inclusion by bare name from the design files
`ifndef CPAA_DEFINES_SVH
`define CPAA_DEFINES_SVH
// ==========================================
// Register select codes
`define CPAA_R_SETUP      8'h00
`define CPAA_R_OPCODE     8'h01
`define CPAA_R_HKEY_LO    8'h02
`define CPAA_R_HKEY_HI    8'h03
`define CPAA_R_HMASK_LO   8'h04
`define CPAA_R_HMASK_HI   8'h05
`define CPAA_R_HSEG       8'h06
`define CPAA_R_HIT_STATE  8'h07
`define CPAA_R_ENTRY_ST   8'h08
`define CPAA_R_HIT_ADDR   8'h09
`define CPAA_R_SEG_HIT    8'h0a
`define CPAA_R_CMP        8'h0b
`define CPAA_R_HDATA      8'h0c
`define CPAA_R_TBL_ADDR   8'h0e
`define CPAA_R_TBL_LO     8'h0f
`define CPAA_R_TBL_HI     8'h10
`define CPAA_R_TBL_COUNT  8'h11
`define CPAA_R_CHIP_ID    8'h12
`define CPAA_R_MODE       8'h13
`define CPAA_R_STEP_IDX   8'h14
`define CPAA_R_CUT        8'h15
`define CPAA_R_SEGSEL     8'h16
`define CPAA_R_MASK_LO    8'h17
`define CPAA_R_MASK_HI    8'h18
`define CPAA_R_RSEL       8'h19
`define CPAA_R_RSEG       8'h1a
// ==========================================
// Setup and step register fields, reset values
`define CPAA_SU_SWAP      0
`define CPAA_SU_WRPOL     1
`define CPAA_SU_CHREG     2
`define CPAA_SU_IPCH      3
`define CPAA_SU_OPCH      4
`define CPAA_SU_IPST      7:5
`define CPAA_SU_OPST      10:8
`define CPAA_SETUP_RST    16'h0000
`define CPAA_COUNT_RST    5'h10
`define CPAA_STEP_END     15
// ==========================================
// Opcodes
`define CPAA_OP_GO_HOST   8'h01
`define CPAA_OP_GO_IDLE   8'h02
`define CPAA_OP_SOFT_RST  8'h03
`define CPAA_OP_SEQ_RST   8'h04
`define CPAA_OP_SEEK      8'h05
`define CPAA_OP_TC_START  8'h06
`define CPAA_OP_TC_END    8'h07
`define CPAA_OP_ID_START  8'h08
`define CPAA_OP_ID_END    8'h09
`define CPAA_OP_CLEAR     8'h0a
`endif

// File: inc/cpaa_pkg.sv
// Types shared by the port access arbiter
// Assumes nothing beyond a SystemVerilog compiler
package cpaa_pkg;
  typedef enum logic [3:0] {
    host_phase     = 4'b0001,
    port_idle_wait = 4'b0010,
    input_phase    = 4'b0100,
    output_phase   = 4'b1000
  } cpaa_mode_t;
  typedef enum logic [1:0] {
    res_status = 2'h0,
    res_addr   = 2'h1,
    res_data   = 2'h2,
    res_key    = 2'h3
  } cpaa_res_t;
endpackage

// File: logic/cpaa_match_table.sv
// Match table: 16 words of flip-flops with a masked parallel compare
// Assumes the caller gates writes and clears by arbitration
`timescale 1ns/1ps
module cpaa_match_table (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_b,
  input  wire logic        i_clk_en,
  // Write side
  input  wire logic        i_we,
  input  wire logic [3:0]  i_widx,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_clear,
  input  wire logic [4:0]  i_count,
  // Search and read side
  input  wire logic [31:0] i_key,
  input  wire logic [31:0] i_mask,
  input  wire logic [3:0]  i_ridx,
  output logic      [31:0] o_rdata,
  output logic      [15:0] o_match,
  output logic             o_hit,
  output logic             o_multi,
  output logic      [3:0]  o_hit_idx
);
  logic [31:0] tbl [16];

  always_ff @(posedge i_clk_sys or negedge i_rst_b)
    if (!i_rst_b)
      for (int i = 0; i < 16; i++) tbl[i] <= 32'h0;
    else if (i_clk_en)
    begin
      if (i_clear)
        for (int i = 0; i < 16; i++) tbl[i] <= 32'h0;
      else if (i_we)
        tbl[i_widx] <= i_wdata;
    end

  // Masked bits (mask 1) never take part in the compare
  always_comb
  begin
    o_hit_idx = 4'h0;
    for (int i = 0; i < 16; i++)
      o_match[i] = (5'(i) < i_count) && (((tbl[i] ^ i_key) & ~i_mask) == 32'h0);
    for (int i = 15; i >= 0; i--)
      if (o_match[i]) o_hit_idx = 4'(i);
  end

  assign o_hit   = |o_match;
  assign o_multi = (o_match & (o_match - 16'h1)) != 16'h0;
  assign o_rdata = tbl[i_ridx];
endmodule

// File: logic/cpaa_port_arbiter.sv
// Port access and arbitration for a three-port match-table search device
// Assumes all strobes and pins are synchronous to i_clk_sys
// Function
// [RULE1] One 32-bit result word per read strobe
// [RULE2] Result port emits status, address, data, key
// [RULE3] Two channels of eight steps, dividable
// [RULE4] 16-bit host data, 8-bit register select
// [RULE5] Each host operation is one strobe low pulse
// [RULE6] Host drives direction during each cycle
// [RULE7] Setup register sets swap, strobe polarity, channel source
// [RULE8] Opcode write launches matching command
// [RULE9] Host loads key, mask, segment before seek
// [RULE10] Host seek is one single search
// [RULE11] Hit results readable; hit data gives entry
// [RULE12] Step registers set cut, segment, mask
// [RULE13] Result select and segment chosen per step
// [RULE14] Host configures table before use
// [RULE15] Host registers chip index when cascaded
// [RULE16] Table ops never overlap port activity
// [RULE17] Three ports mutually exclusive, two methods
// [RULE18] Internal mode tracking with two submodes
// [RULE19] Host mode refuses input and output sequences
// [RULE20] External logic keeps ports exclusive
// [RULE21] External method: only submode restrictions
// [RULE22] Select pin low internal, high external
// [RULE23] Resets and host commands enter host mode
// [RULE24] Go-idle command enters idle waiting mode
// [RULE25] Refused table access and strobes change nothing
`timescale 1ns/1ps
`include "cpaa_defines.svh"
module cpaa_port_arbiter (
  // Clock, reset, enable
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_b,
  input  wire logic        i_clk_en,
  // Arbitration select pin
  input  wire logic        i_arbitration_select,
  // Host register port
  input  wire logic        i_host_ce_b,
  input  wire logic        i_host_rw,
  input  wire logic [7:0]  i_host_addr,
  input  wire logic [15:0] i_host_bus,
  output logic      [15:0] o_host_bus,
  output logic             o_host_bus_oe,
  // Key input port
  input  wire logic        i_key_wr,
  input  wire logic [31:0] i_key_data,
  input  wire logic        i_ip_chan_pin,
  input  wire logic        i_op_chan_pin,
  // Result port
  input  wire logic        i_result_rd_b,
  output logic      [31:0] o_result_bus,
  // Mode status
  output cpaa_pkg::cpaa_mode_t o_mode,
  output logic             o_table_setup_submode,
  output logic             o_chip_index_submode
);
  import cpaa_pkg::*;

  // ==========================================
  // Storage
  logic [15:0] setup, hkey_lo, hkey_hi, hmask_lo, hmask_hi, hseg, tbl_lo, chip_id;
  logic [3:0]  tbl_addr, step_idx, hit_idx;
  logic [4:0]  tbl_count;
  logic [1:0]  cut [16];
  logic [2:0]  sseg [16];
  logic [2:0]  rseg [16];
  logic [31:0] smask [16];
  cpaa_res_t   rsel [16];
  logic        ip_end [16];
  logic        op_end [16];
  logic [2:0]  ip_ptr, op_ptr, hit_seg;
  logic        ip_stop, op_stop, ip_ch, op_ch;
  logic        ce_q, wr_q, rd_q, hit, multi;
  logic [63:0] acc;
  logic [31:0] last_key;
  logic [15:0] hit_vec;

  function automatic logic is_tbl_reg(input logic [7:0] a);
    return a == `CPAA_R_CMP || a == `CPAA_R_HDATA || a == `CPAA_R_TBL_LO
        || a == `CPAA_R_TBL_HI;
  endfunction

  function automatic logic [31:0] swap32(input logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction

  // ==========================================
  // Strobe capture and arbitration
  logic ext, wr_act, host_take, host_wr, host_rd, cmd, allow_tbl, seq_ok;
  logic host_tbl, ip_go, op_go, seek, tbl_we, tbl_clr, seq_rst, soft_rst;
  logic [7:0]  op;
  logic [3:0]  ip_si, op_si, ridx;
  logic [63:0] acc_n;
  logic [31:0] din, key_n, m_rdata;
  logic [15:0] m_match;
  logic        m_hit, m_multi;
  logic [3:0]  m_idx;

  assign ext       = i_arbitration_select;                    // see [RULE22]
  assign wr_act    = setup[`CPAA_SU_WRPOL] ? i_key_wr : ~i_key_wr; // see [RULE7]
  assign host_take = i_clk_en & ~i_host_ce_b & ce_q;           // see [RULE5]
  assign host_wr   = host_take & ~i_host_rw;                   // see [RULE6]
  assign host_rd   = host_take & i_host_rw;
  assign op        = i_host_bus[7:0];
  assign cmd       = host_wr && i_host_addr == `CPAA_R_OPCODE; // see [RULE8]
  // Table ops need host mode only under internal arbitration
  assign allow_tbl = ~o_chip_index_submode & (ext | o_mode == host_phase); // see [RULE16]
  assign seq_ok    = ~o_table_setup_submode & ~o_chip_index_submode;   // see [RULE21]
  assign seek      = cmd && op == `CPAA_OP_SEEK && allow_tbl && !o_table_setup_submode;
  assign tbl_clr   = cmd && op == `CPAA_OP_CLEAR && allow_tbl;
  assign tbl_we    = host_wr && i_host_addr == `CPAA_R_TBL_HI && allow_tbl; // see [RULE25]
  assign soft_rst  = cmd && op == `CPAA_OP_SOFT_RST;
  assign seq_rst   = cmd && (op == `CPAA_OP_SEQ_RST || soft_rst);
  // Host table traffic wins a same-cycle clash with the ports
  assign host_tbl  = host_take & (is_tbl_reg(i_host_addr) | seek | tbl_clr); // see [RULE17]
  assign ip_go     = i_clk_en & wr_act & ~wr_q & seq_ok & ~ip_stop & ~host_tbl
                   & (ext | o_mode == port_idle_wait | o_mode == input_phase); // see [RULE19]
  assign op_go     = i_clk_en & ~i_result_rd_b & rd_q & seq_ok & ~op_stop & ~host_tbl
                   & ~ip_go & (ext | o_mode == port_idle_wait | o_mode == output_phase);
  assign ip_si     = {ip_ch, ip_ptr};                          // see [RULE3]
  assign op_si     = {op_ch, op_ptr};
  assign din       = setup[`CPAA_SU_SWAP] ? swap32(i_key_data) : i_key_data;
  assign acc_n     = {acc[31:0], din};
  assign key_n     = acc_n[{cut[ip_si], 3'b000} +: 32];        // see [RULE12]
  // Hit data reads the entry at the hit address, table data the addressed one
  assign ridx      = (host_take && i_host_addr == `CPAA_R_HDATA) ? hit_idx
                   : host_tbl ? tbl_addr : 4'(hit_idx + {1'b0, rseg[op_si]}); // see [RULE11]

  cpaa_match_table u_table (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_clk_en  (i_clk_en),
    .i_we      (tbl_we),
    .i_widx    (tbl_addr),
    .i_wdata   ({i_host_bus, tbl_lo}),
    .i_clear   (tbl_clr),
    .i_count   (tbl_count),
    .i_key     (ip_go ? key_n : {hkey_hi, hkey_lo}),
    .i_mask    (ip_go ? smask[ip_si] : {hmask_hi, hmask_lo}),
    .i_ridx    (ridx),
    .o_rdata   (m_rdata),
    .o_match   (m_match),
    .o_hit     (m_hit),
    .o_multi   (m_multi),
    .o_hit_idx (m_idx)
  );

  always_ff @(posedge i_clk_sys or negedge i_rst_b)
    if (!i_rst_b)
    begin
      ce_q <= 1'b1;
      wr_q <= 1'b0;
      rd_q <= 1'b1;
    end
    else if (i_clk_en)
    begin
      ce_q <= i_host_ce_b;
      wr_q <= wr_act;
      rd_q <= i_result_rd_b;
    end

  // ==========================================
  // Operating mode
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
    if (!i_rst_b)
    begin
      o_mode                <= host_phase;                     // see [RULE23]
      o_table_setup_submode <= 1'b0;
      o_chip_index_submode  <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (cmd && (op == `CPAA_OP_GO_HOST || soft_rst))
        o_mode <= host_phase;                                  // see [RULE23]
      else if (cmd && op == `CPAA_OP_GO_IDLE && o_mode == host_phase && seq_ok)
        o_mode <= port_idle_wait;                              // see [RULE24]
      else if (ip_go && !ext)
        o_mode <= ip_end[ip_si] ? port_idle_wait : input_phase; // see [RULE18]
      else if (op_go && !ext)
        o_mode <= op_end[op_si] ? port_idle_wait : output_phase;
      if (soft_rst || (cmd && op == `CPAA_OP_TC_END))
        o_table_setup_submode <= 1'b0;
      else if (cmd && op == `CPAA_OP_TC_START && allow_tbl)
        o_table_setup_submode <= 1'b1;
      if (soft_rst || (cmd && op == `CPAA_OP_ID_END))
        o_chip_index_submode <= 1'b0;
      else if (cmd && op == `CPAA_OP_ID_START && (ext || o_mode == host_phase))
        o_chip_index_submode <= 1'b1;
    end

  // ==========================================
  // Host-written configuration
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
    if (!i_rst_b)
    begin
      setup     <= `CPAA_SETUP_RST;
      {hkey_lo, hkey_hi, hmask_lo, hmask_hi, hseg, tbl_lo, chip_id} <= 112'h0;
      tbl_addr  <= 4'h0;
      tbl_count <= `CPAA_COUNT_RST;
    end
    else if (host_wr)
      unique case (i_host_addr)
        `CPAA_R_SETUP:     if (ext || o_mode == host_phase) setup <= i_host_bus; // see [RULE7]
        `CPAA_R_HKEY_LO:   hkey_lo  <= i_host_bus;             // see [RULE9]
        `CPAA_R_HKEY_HI:   hkey_hi  <= i_host_bus;
        `CPAA_R_HMASK_LO:  hmask_lo <= i_host_bus;
        `CPAA_R_HMASK_HI:  hmask_hi <= i_host_bus;
        `CPAA_R_HSEG:      hseg     <= i_host_bus;
        `CPAA_R_TBL_ADDR:  tbl_addr <= i_host_bus[3:0];
        `CPAA_R_TBL_LO:    if (allow_tbl) tbl_lo <= i_host_bus;
        `CPAA_R_TBL_COUNT: if (o_table_setup_submode) tbl_count <= i_host_bus[4:0];
        `CPAA_R_CHIP_ID:   if (o_chip_index_submode) chip_id <= i_host_bus;
        default:           ;
      endcase

  // Per-step sequence definitions, reached through a step index
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
    if (!i_rst_b)
    begin
      step_idx <= 4'h0;
      for (int i = 0; i < 16; i++)
      begin
        cut[i]    <= 2'h0;
        sseg[i]   <= 3'h0;
        rseg[i]   <= 3'h0;
        smask[i]  <= 32'h0;
        rsel[i]   <= res_status;
        ip_end[i] <= 1'b1;
        op_end[i] <= 1'b1;
      end
    end
    else if (host_wr)
      unique case (i_host_addr)
        `CPAA_R_STEP_IDX: step_idx <= i_host_bus[3:0];
        `CPAA_R_CUT:      cut[step_idx] <= i_host_bus[1:0];     // see [RULE12]
        `CPAA_R_SEGSEL:
        begin
          sseg[step_idx]   <= i_host_bus[2:0];
          ip_end[step_idx] <= i_host_bus[`CPAA_STEP_END];
        end
        `CPAA_R_MASK_LO:  smask[step_idx][15:0]  <= i_host_bus;
        `CPAA_R_MASK_HI:  smask[step_idx][31:16] <= i_host_bus;
        `CPAA_R_RSEL:                                          // see [RULE13]
        begin
          rsel[step_idx]   <= cpaa_res_t'(i_host_bus[1:0]);
          op_end[step_idx] <= i_host_bus[`CPAA_STEP_END];
        end
        `CPAA_R_RSEG:     rseg[step_idx] <= i_host_bus[2:0];
        default:          ;
      endcase

  // ==========================================
  // Sequence pointers; an end step stops a channel part-way, dividing it
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
    if (!i_rst_b)
    begin
      {ip_ptr, op_ptr} <= 6'h0;
      {ip_stop, op_stop, ip_ch, op_ch} <= 4'h0;
    end
    else if (seq_rst)
    begin
      ip_ch   <= setup[`CPAA_SU_CHREG] ? setup[`CPAA_SU_IPCH] : i_ip_chan_pin;
      op_ch   <= setup[`CPAA_SU_CHREG] ? setup[`CPAA_SU_OPCH] : i_op_chan_pin;
      ip_ptr  <= setup[`CPAA_SU_IPST];
      op_ptr  <= setup[`CPAA_SU_OPST];
      // A step that ends its channel in the reset cycle still stops it
      ip_stop <= ip_go && ip_end[ip_si];
      op_stop <= op_go && op_end[op_si];
    end
    else
    begin
      if (ip_go && ip_end[ip_si]) ip_stop <= 1'b1;             // see [RULE3]
      else if (ip_go) ip_ptr <= ip_ptr + 3'h1;
      if (op_go && op_end[op_si]) op_stop <= 1'b1;
      else if (op_go) op_ptr <= op_ptr + 3'h1;
    end

  // ==========================================
  // Search results: host seek is one lookup, no stepping
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
    if (!i_rst_b)
    begin
      {hit, multi, hit_idx, hit_seg, hit_vec} <= 25'h0;
      acc      <= 64'h0;
      last_key <= 32'h0;
    end
    else if (ip_go || seek)                                    // see [RULE10]
    begin
      hit     <= m_hit;                                        // see [RULE11]
      multi   <= m_multi;
      hit_idx <= m_idx;
      hit_vec <= m_match;
      hit_seg <= ip_go ? sseg[ip_si] : hseg[2:0];
      if (ip_go)
      begin
        acc      <= acc_n;
        last_key <= key_n;
      end
    end

  // Result port: one word per read strobe
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
    if (!i_rst_b)
      o_result_bus <= 32'h0;
    else if (op_go)                                            // see [RULE1]
      unique case (rsel[op_si])                                // see [RULE2]
        res_status: o_result_bus <= {hit_seg, 27'h0, multi, hit};
        res_addr:   o_result_bus <= {28'h0, hit_idx};
        res_data:   o_result_bus <= m_rdata;
        res_key:    o_result_bus <= last_key;
      endcase

  // ==========================================
  // Host read path; refused table reads answer zero
  logic [15:0] rd_mux;
  always_comb
  begin
    rd_mux = 16'h0;
    unique case (i_host_addr)                                  // see [RULE4]
      `CPAA_R_SETUP:     rd_mux = setup;
      `CPAA_R_HKEY_LO:   rd_mux = hkey_lo;
      `CPAA_R_HKEY_HI:   rd_mux = hkey_hi;
      `CPAA_R_HMASK_LO:  rd_mux = hmask_lo;
      `CPAA_R_HMASK_HI:  rd_mux = hmask_hi;
      `CPAA_R_HSEG:      rd_mux = hseg;
      `CPAA_R_HIT_STATE: rd_mux = {14'h0, multi, hit};         // see [RULE11]
      `CPAA_R_ENTRY_ST:  rd_mux = {ip_stop, op_stop, 9'h0, tbl_count};
      `CPAA_R_HIT_ADDR:  rd_mux = {12'h0, hit_idx};
      `CPAA_R_SEG_HIT:   rd_mux = {13'h0, hit_seg};
      `CPAA_R_CMP:       rd_mux = allow_tbl ? hit_vec : 16'h0;
      `CPAA_R_HDATA:     rd_mux = allow_tbl ? m_rdata[15:0] : 16'h0;
      `CPAA_R_TBL_LO:    rd_mux = allow_tbl ? m_rdata[15:0] : 16'h0;
      `CPAA_R_TBL_HI:    rd_mux = allow_tbl ? m_rdata[31:16] : 16'h0;
      `CPAA_R_TBL_ADDR:  rd_mux = {12'h0, tbl_addr};
      `CPAA_R_TBL_COUNT: rd_mux = {11'h0, tbl_count};
      `CPAA_R_CHIP_ID:   rd_mux = chip_id;
      `CPAA_R_MODE:      rd_mux = {9'h0, ext, o_chip_index_submode,
                                   o_table_setup_submode, o_mode};
      `CPAA_R_STEP_IDX:  rd_mux = {12'h0, step_idx};
      default:           rd_mux = 16'h0;
    endcase
  end

  // Read data stands until the next read; enable drops once the strobe is high
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
    if (!i_rst_b)
    begin
      o_host_bus    <= 16'h0;
      o_host_bus_oe <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (host_rd)
      begin
        o_host_bus    <= rd_mux;
        o_host_bus_oe <= 1'b1;
      end
      else if (i_host_ce_b)
        o_host_bus_oe <= 1'b0;
    end

  // ==========================================
  // Checks
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  sequence s_go_idle;
    cmd && op == `CPAA_OP_GO_IDLE && o_mode == host_phase && seq_ok;
  endsequence
  sequence s_ip_last;
    ip_go && ip_end[ip_si] && !seq_rst;
  endsequence

  AST_HOST_NO_SEQ: assert property (!ext && o_mode == host_phase |-> !ip_go && !op_go) // see [RULE19]
    else $error("Port step started in host mode");
  AST_TBL_FROZEN: assert property (!ext && o_mode != host_phase |-> !tbl_we && !tbl_clr) // see [RULE25]
    else $error("Table changed outside host mode");
  AST_GO_IDLE: assert property (s_go_idle |=> o_mode == port_idle_wait) // see [RULE24]
    else $error("Go-idle did not reach idle");
  AST_SOFT_RESET: assert property (soft_rst |=> o_mode == host_phase && seq_ok) // see [RULE23]
    else $error("Soft reset did not enter host mode");
  AST_EXCLUSIVE: assert property (!(ip_go && op_go) && !(host_tbl && (ip_go || op_go))) // see [RULE17]
    else $error("Two ports touched the table together");
  AST_SETUP_LOCK: assert property (!ext && o_mode != host_phase && host_wr
      && i_host_addr == `CPAA_R_SETUP |=> $stable(setup)) // see [RULE7]
    else $error("Setup written outside host mode");
  AST_IP_STOP: assert property (s_ip_last ##1 !seq_rst [*2] |-> ip_stop && !ip_go) // see [RULE3]
    else $error("Input sequence ran past its end step");
  AST_KEY_OUT: assert property (op_go && rsel[op_si] == res_key |=> o_result_bus == last_key) // see [RULE1]
    else $error("Key result word wrong");
  AST_SUBMODE: assert property (o_table_setup_submode || o_chip_index_submode
      |-> !ip_go && !op_go) // see [RULE21]
    else $error("Port step during submode");
  AST_HIT_READ: assert property (host_rd && i_host_addr == `CPAA_R_HIT_STATE
      |=> o_host_bus_oe && o_host_bus[1:0] == {$past(multi), $past(hit)}) // see [RULE11]
    else $error("Hit state read wrong");
endmodule

// File: verif/cpaa_host_model.sv
// Host processor and result reader standing at the far side of the arbiter
// Assumes the system clock is free running; drives only at falling edges
`timescale 1ns/1ps
module cpaa_host_model (
  // Clock
  input  wire logic        i_clk_sys,
  // Host port
  output logic             o_ce_b,
  output logic             o_rw,
  output logic      [7:0]  o_addr,
  output logic      [15:0] o_wdata,
  input  wire logic [15:0] i_rdata,
  // Result port
  output logic             o_rd_b,
  input  wire logic [31:0] i_result
);
  initial
  begin
    o_ce_b  = 1'b1;
    o_rw    = 1'b1;
    o_addr  = 8'h00;
    o_wdata = 16'h0000;
    o_rd_b  = 1'b1;
  end
  // ==========================================
  // Accesses run one at a time, so ports never overlap
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge i_clk_sys);
    o_addr  = a;
    o_wdata = d;
    o_rw    = 1'b0;
    o_ce_b  = 1'b0;
    @(negedge i_clk_sys);
    o_ce_b  = 1'b1;
    o_wdata = ~d;    // Released bus must not look like held data
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge i_clk_sys);
    o_addr = a;
    o_rw   = 1'b1;
    o_ce_b = 1'b0;
    @(negedge i_clk_sys);
    d      = i_rdata;
    o_ce_b = 1'b1;
  endtask
  task automatic res(output logic [31:0] d);
    @(negedge i_clk_sys);
    o_rd_b = 1'b0;
    @(negedge i_clk_sys);
    d      = i_result;
    o_rd_b = 1'b1;
  endtask
endmodule

// File: verif/cpaa_port_arbiter_tb_top.sv
// Self-checking bench for the port arbiter
// Assumes the host model above and the design's default reset values
`timescale 1ns/1ps
`include "cpaa_defines.svh"
module cpaa_port_arbiter_tb_top;
  import cpaa_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        arb_sel = 1'b0;
  logic        key_wr = 1'b1;
  logic [31:0] key_data = 32'h0;
  logic        ce_b, rw, rd_b, oe, tc_sub, id_sub;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, v;
  logic [31:0] result, w;
  cpaa_mode_t  mode;
  int          n_errors = 0;
  int          comparisons = 0;
  always #5 clk = ~clk;
  cpaa_host_model i_host (.i_clk_sys(clk), .o_ce_b(ce_b), .o_rw(rw), .o_addr(addr),
    .o_wdata(wdata), .i_rdata(rdata), .o_rd_b(rd_b), .i_result(result));
  cpaa_port_arbiter i_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_clk_en(1'b1),
    .i_arbitration_select(arb_sel), .i_host_ce_b(ce_b), .i_host_rw(rw),
    .i_host_addr(addr), .i_host_bus(wdata), .o_host_bus(rdata), .o_host_bus_oe(oe),
    .i_key_wr(key_wr), .i_key_data(key_data), .i_ip_chan_pin(1'b0),
    .i_op_chan_pin(1'b0), .i_result_rd_b(rd_b), .o_result_bus(result), .o_mode(mode),
    .o_table_setup_submode(tc_sub), .o_chip_index_submode(id_sub));
  // ==========================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic key_pulse(input logic [31:0] d);
    @(negedge clk);
    key_data = d;
    key_wr   = 1'b0;
    @(negedge clk);
    key_wr   = 1'b1;
  endtask
  // Host search: key loaded before the command
  task automatic seek(input logic [15:0] hi);
    i_host.wr(`CPAA_R_HKEY_LO, 16'habcd);
    i_host.wr(`CPAA_R_HKEY_HI, hi);
    i_host.wr(`CPAA_R_HMASK_LO, 16'h0000);
    i_host.wr(`CPAA_R_HMASK_HI, 16'h0000);
    i_host.wr(`CPAA_R_HSEG, 16'h0000);
    i_host.wr(`CPAA_R_OPCODE, {8'h00, `CPAA_OP_SEEK});
  endtask
  // ==========================================
  // Scenarios
  task automatic t_setup_table;
    i_host.wr(`CPAA_R_SETUP, 16'h0004);
    i_host.rd(`CPAA_R_SETUP, v);
    chk(v, 16'h0004);
    chk(oe, 1'b1);
    i_host.wr(`CPAA_R_OPCODE, {8'h00, `CPAA_OP_TC_START});
    chk(tc_sub, 1'b1);
    chk(oe, 1'b0);
    i_host.wr(`CPAA_R_TBL_COUNT, 16'h0010);
    i_host.wr(`CPAA_R_OPCODE, {8'h00, `CPAA_OP_TC_END});
    chk(tc_sub, 1'b0);
    i_host.wr(`CPAA_R_TBL_ADDR, 16'h0003);
    i_host.wr(`CPAA_R_TBL_LO, 16'habcd);
    i_host.wr(`CPAA_R_TBL_HI, 16'h1234);
    i_host.rd(`CPAA_R_TBL_HI, v);
    chk(v, 16'h1234);
  endtask
  task automatic t_host_seek;
    seek(16'h1234);
    i_host.rd(`CPAA_R_HIT_STATE, v);
    chk(v, 16'h0001);
    i_host.rd(`CPAA_R_HIT_ADDR, v);
    chk(v, 16'h0003);
    // Table pointer moved away so hit data must follow the hit address
    i_host.wr(`CPAA_R_TBL_ADDR, 16'h0005);
    i_host.rd(`CPAA_R_HDATA, v);
    chk(v, 16'habcd);
    i_host.wr(`CPAA_R_TBL_ADDR, 16'h0003);
    seek(16'hffff);
    i_host.rd(`CPAA_R_HIT_STATE, v);
    chk(v, 16'h0000);
  endtask
  // Internal method: host mode refuses ports, idle refuses table access
  task automatic t_internal;
    key_pulse(32'h1234abcd);
    i_host.rd(`CPAA_R_HIT_STATE, v);
    chk(v, 16'h0000);
    i_host.wr(`CPAA_R_OPCODE, {8'h00, `CPAA_OP_GO_IDLE});
    chk(mode, port_idle_wait);
    i_host.wr(`CPAA_R_TBL_LO, 16'h0000);
    i_host.wr(`CPAA_R_TBL_HI, 16'h0000);
    i_host.wr(`CPAA_R_SETUP, 16'h0001);
    i_host.rd(`CPAA_R_SETUP, v);
    chk(v, 16'h0004);
    key_pulse(32'h1234abcd);
    chk(mode, port_idle_wait);
    i_host.res(w);
    chk(w, 32'h00000001);
    i_host.res(w);
    chk(mode, port_idle_wait);
    chk(w, 32'h00000001);
    i_host.rd(`CPAA_R_ENTRY_ST, v);
    chk(v, 16'hc010);
    i_host.wr(`CPAA_R_OPCODE, {8'h00, `CPAA_OP_GO_HOST});
    chk(mode, host_phase);
    i_host.rd(`CPAA_R_TBL_LO, v);
    chk(v, 16'habcd);
  endtask
  // External method: a key strobe works even in host mode
  task automatic t_external;
    @(negedge clk);
    arb_sel = 1'b1;
    i_host.wr(`CPAA_R_OPCODE, {8'h00, `CPAA_OP_SEQ_RST});
    seek(16'hffff);
    key_pulse(32'h1234abcd);
    i_host.rd(`CPAA_R_HIT_STATE, v);
    chk(v, 16'h0001);
    chk(mode, host_phase);
    i_host.wr(`CPAA_R_RSEL, 16'h8003);
    i_host.res(w);
    chk(w, 32'h1234abcd);
  endtask
  // Chip index submode blocks port steps; soft reset leaves it for host mode
  task automatic t_chip_index;
    i_host.wr(`CPAA_R_OPCODE, {8'h00, `CPAA_OP_ID_START});
    chk(id_sub, 1'b1);
    i_host.wr(`CPAA_R_OPCODE, {8'h00, `CPAA_OP_SEQ_RST});
    key_pulse(32'h5555aaaa);
    i_host.rd(`CPAA_R_HIT_STATE, v);
    chk(v, 16'h0001);
    i_host.wr(`CPAA_R_CHIP_ID, 16'h0005);
    i_host.rd(`CPAA_R_CHIP_ID, v);
    chk(v, 16'h0005);
    i_host.wr(`CPAA_R_OPCODE, {8'h00, `CPAA_OP_SOFT_RST});
    chk({id_sub, mode}, {1'b0, host_phase});
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial
  begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    chk(mode, host_phase);
    chk(result, 32'h0);
    t_setup_table();
    t_host_seek();
    t_internal();
    t_external();
    t_chip_index();
    end_sim();
  end
  initial
  begin
    #50us;
    n_errors++;
    end_sim();
  end
endmodule
